//--- design/tra_defs.vh
// Constants for the temperature readout and alert response block.
`ifndef TRA_DEFS_VH
`define TRA_DEFS_VH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define TRA_ADDR_UPPER    5'h0B
`define TRA_ARA_ADDR      7'h0C
`define TRA_STRAP_GND     2'h0
`define TRA_STRAP_VCC     2'h1
`define TRA_STRAP_OPEN    2'h2

// ----------------------------------------------------------------------
// Register offsets, field positions and reset values
// ----------------------------------------------------------------------
`define TRA_REG_EXT_FRAC  8'h06
`define TRA_REG_LOCAL_HI  8'h0A
`define TRA_REG_REMOTE_HI 8'h0B
`define TRA_EXT_REM_MSB   7
`define TRA_EXT_REM_LSB   5
`define TRA_EXT_LOC_MSB   4
`define TRA_EXT_LOC_LSB   3
`define TRA_RESET_BYTE    8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TRA_CLK_MHZ       250
`define TRA_CONV_TIME_US  9600
`define TRA_AVG_COUNT     16
`define TRA_STRAP_WAIT    4'hF

`endif

//--- design/tra_avg.v
// Sixteen-sample averaging filter for the remote temperature channel.
`timescale 1ns/1ps
module tra_avg (
   // Clock and reset.
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Raw converter samples, 11-bit two's complement.
   input  wire [10:0] sample_i,
   input  wire        valid_i,
   // Averaged result and its completion pulse.
   output reg  [10:0] avg_o,
   output reg         done_o
);

   reg  [14:0] acc_reg;
   reg  [3:0]  cnt_reg;
   wire [14:0] sum;

   // Sign extension keeps negative readings correct through the sum.
   assign sum = acc_reg + {{4{sample_i[10]}}, sample_i};

   // ------------------------------------------------------------------
   // Accumulate
   // ------------------------------------------------------------------
   // The shift drops four bits, so the average truncates toward minus
   // infinity; that costs at most one eighth of a degree.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_reg <= 15'h0000;
         cnt_reg <= 4'h0;
         avg_o   <= 11'h000;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (valid_i) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'hF) begin
               acc_reg <= 15'h0000;
               avg_o   <= sum[14:4];
               done_o  <= 1'b1;
            end else begin
               acc_reg <= sum;
            end
         end
      end
   end

endmodule

//--- design/tra_top.v
// Temperature result registers with a bus slave and alert response.
`timescale 1ns/1ps
`include "tra_defs.vh"
module tra_top #(
   parameter CONV_CYCLES = `TRA_CONV_TIME_US * `TRA_CLK_MHZ
) (
   // Clock and reset.
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Serial bus pins; data is open-drain.
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   // Open-drain interrupt, usable as the shared alert line.
   output reg         int_o,
   output reg         int_oe_o,
   // Three-state address strap as sensed by the pad.
   input  wire [1:0]  strap_level_i,
   // Converter side, same clock domain.
   output reg         adc_start_o,
   input  wire [10:0] remote_sample_i,
   input  wire        remote_valid_i,
   input  wire [9:0]  local_sample_i,
   input  wire        local_valid_i,
   // Limit logic reports a standing error condition.
   input  wire        alert_cond_i
);

   localparam [31:0] SUB_WIDE = CONV_CYCLES / `TRA_AVG_COUNT - 32'h1;
   localparam [21:0] SUB_LAST = SUB_WIDE[21:0];

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ADDR = 4'h1;
   localparam [3:0] S_ADEC = 4'h2;
   localparam [3:0] S_AACK = 4'h3;
   localparam [3:0] S_WRB  = 4'h4;
   localparam [3:0] S_WDEC = 4'h5;
   localparam [3:0] S_WACK = 4'h6;
   localparam [3:0] S_RDB  = 4'h7;
   localparam [3:0] S_RREL = 4'h8;
   localparam [3:0] S_RACK = 4'h9;
   localparam [3:0] S_LOAD = 4'hA;

   // Three-state strap decode; an unexpected code is treated as open.
   function [1:0] strap_bits;
      input [1:0] lvl;
      begin
         case (lvl)
            `TRA_STRAP_GND: strap_bits = 2'h0;
            `TRA_STRAP_VCC: strap_bits = 2'h1;
            default:        strap_bits = 2'h2;
         endcase
      end
   endfunction

   reg  [1:0]  scl_sync_reg, sda_sync_reg, strap_s1_reg, strap_s2_reg;
   reg         scl_prev_reg, sda_prev_reg;
   reg  [3:0]  strap_wait_reg;
   reg         strap_done_reg;
   reg         bus_addr_bit1_reg, bus_addr_bit0_reg;
   reg  [21:0] sub_cnt_reg;
   wire [10:0] remote_avg;
   wire        remote_done;
   reg  [7:0]  local_hi_reg, remote_hi_reg, ext_frac_reg;
   reg  [3:0]  state_reg;
   reg  [2:0]  bit_cnt_reg;
   reg  [7:0]  shift_reg, tx_reg, pointer_reg;
   reg         rw_reg, is_ara_reg, lost_reg, wr_first_reg, ara_done_reg;
   wire        scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
   wire [6:0]  own_addr;
   reg  [7:0]  rd_data;

   assign scl        = scl_sync_reg[1];
   assign sda        = sda_sync_reg[1];
   assign scl_rise   = scl & ~scl_prev_reg;
   assign scl_fall   = ~scl & scl_prev_reg;
   assign start_cond = scl & scl_prev_reg & ~sda & sda_prev_reg;
   assign stop_cond  = scl & scl_prev_reg & sda & ~sda_prev_reg;
   assign own_addr   = {`TRA_ADDR_UPPER, bus_addr_bit1_reg,
                        bus_addr_bit0_reg};

   // ------------------------------------------------------------------
   // Pin synchronisers and strap capture
   // ------------------------------------------------------------------
   // The strap is caught a few cycles after reset release so that it has
   // passed the synchroniser; later changes are ignored until a reset.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_sync_reg      <= 2'h3;
         sda_sync_reg      <= 2'h3;
         scl_prev_reg      <= 1'b1;
         sda_prev_reg      <= 1'b1;
         strap_s1_reg      <= 2'h0;
         strap_s2_reg      <= 2'h0;
         strap_wait_reg    <= 4'h0;
         strap_done_reg    <= 1'b0;
         bus_addr_bit1_reg <= 1'b0;
         bus_addr_bit0_reg <= 1'b0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         scl_prev_reg <= scl;
         sda_prev_reg <= sda;
         strap_s1_reg <= strap_level_i;
         strap_s2_reg <= strap_s1_reg;
         if (!strap_done_reg) begin
            strap_wait_reg <= strap_wait_reg + 4'h1;
            if (strap_wait_reg == `TRA_STRAP_WAIT) begin
               strap_done_reg <= 1'b1;
               {bus_addr_bit1_reg, bus_addr_bit0_reg} <=
                  strap_bits(strap_s2_reg);
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Measurement pacing and remote averaging
   // ------------------------------------------------------------------
   // Sixteen converter starts per averaged result give the full period.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sub_cnt_reg <= 22'h000000;
         adc_start_o <= 1'b0;
      end else begin
         adc_start_o <= (sub_cnt_reg == SUB_LAST);
         if (sub_cnt_reg == SUB_LAST)
            sub_cnt_reg <= 22'h000000;
         else
            sub_cnt_reg <= sub_cnt_reg + 22'h000001;
      end
   end

   tra_avg u_avg (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .sample_i (remote_sample_i),
      .valid_i  (remote_valid_i),
      .avg_o    (remote_avg),
      .done_o   (remote_done)
   );

   // ------------------------------------------------------------------
   // Result registers
   // ------------------------------------------------------------------
   // Each channel writes its integer byte and its fraction in one edge,
   // and a read loads its whole byte at once, so nothing tears.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         local_hi_reg  <= `TRA_RESET_BYTE;
         remote_hi_reg <= `TRA_RESET_BYTE;
         ext_frac_reg  <= `TRA_RESET_BYTE;
      end else begin
         if (remote_done) begin
            remote_hi_reg <= remote_avg[10:3];
            ext_frac_reg[`TRA_EXT_REM_MSB:`TRA_EXT_REM_LSB] <=
               remote_avg[2:0];
         end
         if (local_valid_i) begin
            local_hi_reg <= local_sample_i[9:2];
            ext_frac_reg[`TRA_EXT_LOC_MSB:`TRA_EXT_LOC_LSB] <=
               local_sample_i[1:0];
         end
      end
   end

   // Read multiplexer; unmapped pointers read as zero.
   always @* begin
      case (pointer_reg)
         `TRA_REG_EXT_FRAC:  rd_data = ext_frac_reg;
         `TRA_REG_LOCAL_HI:  rd_data = local_hi_reg;
         `TRA_REG_REMOTE_HI: rd_data = remote_hi_reg;
         default:            rd_data = `TRA_RESET_BYTE;
      endcase
   end

   // ------------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------------
   // A new monitoring result with the cause present wins over a release
   // in the same cycle. The pin only ever pulls low.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_o    <= 1'b0;
         int_oe_o <= 1'b0;
      end else begin
         int_o <= 1'b0;
         if (remote_done && alert_cond_i)
            int_oe_o <= 1'b1;
         else if (ara_done_reg)
            int_oe_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Serial bus slave
   // ------------------------------------------------------------------
   // Inputs sampled on rising clock, data changed on falling clock.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg    <= S_IDLE;
         bit_cnt_reg  <= 3'h0;
         shift_reg    <= 8'h00;
         tx_reg       <= 8'h00;
         pointer_reg  <= 8'h00;
         rw_reg       <= 1'b0;
         is_ara_reg   <= 1'b0;
         lost_reg     <= 1'b0;
         wr_first_reg <= 1'b0;
         ara_done_reg <= 1'b0;
         sda_o        <= 1'b0;
         sda_oe_o     <= 1'b0;
      end else begin
         ara_done_reg <= 1'b0;
         sda_o        <= 1'b0;
         if (start_cond) begin
            state_reg   <= S_ADDR;
            bit_cnt_reg <= 3'h0;
            lost_reg    <= 1'b0;
            sda_oe_o    <= 1'b0;
         end else if (stop_cond) begin
            state_reg <= S_IDLE;
            sda_oe_o  <= 1'b0;
         end else if (scl_rise) begin
            case (state_reg)
               S_ADDR, S_WRB: begin
                  shift_reg   <= {shift_reg[6:0], sda};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7)
                     state_reg <= (state_reg == S_ADDR) ? S_ADEC : S_WDEC;
               end
               S_RDB: begin
                  // Sending a one while the line reads low means another
                  // device with a lower address is winning.
                  if (!sda_oe_o && !sda)
                     lost_reg <= 1'b1;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7)
                     state_reg <= S_RREL;
               end
               S_RACK: state_reg <= sda ? S_IDLE : S_LOAD;
               default: state_reg <= state_reg;
            endcase
         end else if (scl_fall) begin
            case (state_reg)
               S_ADEC: begin
                  rw_reg     <= shift_reg[0];
                  is_ara_reg <= (shift_reg[7:1] == `TRA_ARA_ADDR);
                  // Own address never equals the ARA, so no overlap here.
                  if (shift_reg[7:1] == own_addr) begin
                     sda_oe_o     <= 1'b1;
                     wr_first_reg <= 1'b1;
                     state_reg    <= S_AACK;
                  end else if (shift_reg == {`TRA_ARA_ADDR, 1'b1} &&
                               int_oe_o) begin
                     sda_oe_o  <= 1'b1;
                     state_reg <= S_AACK;
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end
               S_AACK, S_LOAD: begin
                  if (state_reg == S_AACK && !rw_reg) begin
                     sda_oe_o    <= 1'b0;
                     bit_cnt_reg <= 3'h0;
                     state_reg   <= S_WRB;
                  end else if (is_ara_reg) begin
                     sda_oe_o    <= ~own_addr[6];
                     tx_reg      <= {own_addr[5:0], 2'h0};
                     bit_cnt_reg <= 3'h0;
                     state_reg   <= S_RDB;
                  end else begin
                     sda_oe_o    <= ~rd_data[7];
                     tx_reg      <= {rd_data[6:0], 1'b0};
                     bit_cnt_reg <= 3'h0;
                     state_reg   <= S_RDB;
                  end
               end
               S_RDB: begin
                  sda_oe_o <= ~tx_reg[7] & ~lost_reg;
                  tx_reg   <= {tx_reg[6:0], 1'b0};
               end
               S_RREL: begin
                  sda_oe_o     <= 1'b0;
                  ara_done_reg <= is_ara_reg & ~lost_reg;
                  state_reg    <= lost_reg ? S_IDLE : S_RACK;
               end
               S_WDEC: begin
                  // All result registers are read-only; data bytes after
                  // the pointer are acknowledged and dropped.
                  sda_oe_o <= 1'b1;
                  if (wr_first_reg)
                     pointer_reg <= shift_reg;
                  wr_first_reg <= 1'b0;
                  state_reg    <= S_WACK;
               end
               S_WACK: begin
                  sda_oe_o    <= 1'b0;
                  bit_cnt_reg <= 3'h0;
                  state_reg   <= S_WRB;
               end
               default: state_reg <= state_reg;
            endcase
         end
      end
   end

endmodule

//--- tb/tra_top_monitor.sv
// Concurrent checks on the pins of the temperature readout block.
`timescale 1ns/1ps
module tra_top_monitor #(
   parameter CONV_CYCLES = 160
) (
   // Clock and reset.
   input wire        clock_i,
   input wire        rst_n_i,
   // Bus and interrupt pins.
   input wire        scl_i,
   input wire        sda_i,
   input wire        sda_o,
   input wire        sda_oe_o,
   input wire        int_o,
   input wire        int_oe_o,
   // Strap, converter and limit side.
   input wire [1:0]  strap_level_i,
   input wire        adc_start_o,
   input wire [10:0] remote_sample_i,
   input wire        remote_valid_i,
   input wire [9:0]  local_sample_i,
   input wire        local_valid_i,
   input wire        alert_cond_i
);
   localparam int SUB = CONV_CYCLES / 16;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // An open-drain pin may only ever pull low.
   a_sda_open_drain: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   a_int_open_drain: assert property (int_o == 1'b0)
      else $error("interrupt pin driven high");
   // Sixteen evenly spaced starts make one averaged result.
   a_adc_period: assert property (adc_start_o |-> ##SUB adc_start_o)
      else $error("converter start spacing wrong");
   a_adc_gap: assert property (adc_start_o |=> !adc_start_o [*8])
      else $error("converter start too soon");
   // Interrupt only rises at a monitoring cycle with a standing cause.
   a_int_cause: assert property ($rose(int_oe_o) |->
      $past(alert_cond_i))
      else $error("interrupt without cause");
   a_int_at_result: assert property ($rose(int_oe_o) |->
      $past(remote_valid_i, 2) || $past(remote_valid_i, 3) ||
      $past(remote_valid_i, 4))
      else $error("interrupt away from a result");
   // Release follows the last address bit of an answered query.
   a_int_release: assert property ($fell(int_oe_o) |->
      !$past(sda_oe_o) && ($past(sda_oe_o, 2) || $past(sda_oe_o, 3)))
      else $error("interrupt released outside a query");
   a_int_hold_high: assert property (int_oe_o && scl_i |=> int_oe_o)
      else $error("interrupt dropped with clock high");
   // Data may only move while the bus clock is low.
   a_sda_on_low: assert property ($changed(sda_oe_o) |->
      !scl_i && !$past(scl_i, 2))
      else $error("data changed with clock high");
   c_int_set: cover property ($rose(int_oe_o));
   c_int_clear: cover property ($fell(int_oe_o));
   c_adc_start: cover property (adc_start_o);
endmodule

//--- tb/tra_conv_model.sv
// Converter model that answers each enabled start with one remote and local sample.
`timescale 1ns/1ps
module tra_conv_model (
   // Clock and request.
   input  wire         clock_i,
   input  wire         start_i,
   input  wire         en_i,
   // Values to report; spread alternates about the remote value.
   input  wire  [10:0] rem_i,
   input  wire  [10:0] spread_i,
   input  wire  [9:0]  loc_i,
   // Samples and their one-cycle qualifiers.
   output logic [10:0] rsamp_o = 11'h000,
   output logic        rvalid_o = 1'b0,
   output logic [9:0]  lsamp_o = 10'h000,
   output logic        lvalid_o = 1'b0
);
   logic idx = 1'b0;
   // Samples toggle outside their valid cycle so stale data never passes.
   always @(posedge clock_i) begin
      rvalid_o <= 1'b0;
      lvalid_o <= 1'b0;
      rsamp_o <= ~rsamp_o;
      lsamp_o <= ~lsamp_o;
      if (start_i && en_i) begin
         idx <= ~idx;
         rsamp_o <= idx ? rem_i + spread_i : rem_i - spread_i;
         lsamp_o <= loc_i;
         rvalid_o <= 1'b1;
         lvalid_o <= 1'b1;
      end
   end
endmodule

//--- tb/tb_temp_readout_alert_response.sv
// Self-checking bench for the temperature readout and alert block.
`timescale 1ns/1ps
module tb_temp_readout_alert_response;
   logic        clock_i, rst_n_i, scl, m_low, cond, en;
   logic [1:0]  strap;
   logic [10:0] rem, spread;
   logic [9:0]  loc;
   logic [6:0]  addr;
   logic [7:0]  q, eh, el, ee;
   logic        k;
   logic [44:0] rows [0:3];
   int          n_fail, n_checks;
   wire         sda_o, sda_oe_o, int_o, int_oe_o, adc_start_o, rv, lv;
   wire  [10:0] rs;
   wire  [9:0]  ls;
   wire         sda = !(m_low | sda_oe_o);
   tra_top #(.CONV_CYCLES(160)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .int_o(int_o), .int_oe_o(int_oe_o), .strap_level_i(strap),
      .adc_start_o(adc_start_o), .remote_sample_i(rs), .remote_valid_i(rv),
      .local_sample_i(ls), .local_valid_i(lv), .alert_cond_i(cond));
   tra_conv_model u_conv (.clock_i(clock_i), .start_i(adc_start_o),
      .en_i(en), .rem_i(rem), .spread_i(spread), .loc_i(loc),
      .rsamp_o(rs), .rvalid_o(rv), .lsamp_o(ls), .lvalid_o(lv));
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // One bit: data set in the low phase, sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      m_low <= !b;
      tick(10);
      scl <= 1'b1;
      tick(5);
      r = sda;
      tick(5);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(1'b1, a);
      ack = !a;
   endtask
   task automatic bus_start;
      m_low <= 1'b0;
      tick(5);
      scl <= 1'b1;
      tick(10);
      m_low <= 1'b1;
      tick(10);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic bus_stop;
      m_low <= 1'b1;
      tick(10);
      scl <= 1'b1;
      tick(10);
      m_low <= 1'b0;
      tick(10);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      bus_start;
      xfer({addr, 1'b0}, q, k);
      xfer(p, q, k);
      xfer(d, q, k);
      bus_stop;
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] r);
      bus_start;
      xfer({addr, 1'b0}, r, k);
      chk({7'h00, k}, 8'h01);
      xfer(p, r, k);
      bus_start;
      xfer({addr, 1'b1}, r, k);
      xfer(8'hFF, r, k);
      bus_stop;
   endtask
   task automatic probe(input logic [6:0] a, output logic ack);
      bus_start;
      xfer({a, 1'b0}, q, ack);
      bus_stop;
   endtask
   // Alert query; a second alerting device is mimicked through drv.
   task automatic ara(input logic [7:0] drv, output logic [7:0] r,
                      output logic ack);
      logic x;
      bus_start;
      xfer(8'h19, r, ack);
      xfer(drv, r, x);
      bus_stop;
   endtask
   task automatic wait_int;
      for (int n = 0; n < 400 && int_oe_o !== 1'b1; n++) tick(1);
      chk({7'h00, sda & int_oe_o}, 8'h01);
   endtask
   task automatic wait_valid(input int c);
      repeat (c) begin
         tick(1);
         while (rv !== 1'b1) tick(1);
      end
   endtask
   task automatic pwr(input logic [1:0] s);
      strap <= s;
      rst_n_i <= 1'b0;
      tick(6);
      rst_n_i <= 1'b1;
      tick(30);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ------------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   initial begin
      tick(80000);
      n_fail++;
      report_and_stop;
   end
   initial begin
      rst_n_i = 0; scl = 1; m_low = 0; cond = 0; en = 0; strap = 2'h2;
      rem = 0; spread = 0; loc = 0; addr = 7'h2E; n_fail = 0; n_checks = 0;
      rows[0] = {11'h7FF, 10'h3FD, 8'hFF, 8'hFF, 8'hE8};
      rows[1] = {11'h3FF, 10'h1FF, 8'h7F, 8'h7F, 8'hF8};
      rows[2] = {11'h400, 10'h200, 8'h80, 8'h80, 8'h00};
      rows[3] = {11'h0C9, 10'h065, 8'h19, 8'h19, 8'h28};
      // Every strap level selects its address; fraction and remote bytes start cleared.
      for (int s = 0; s < 4; s++) begin
         pwr(s[1:0]);
         addr = {5'h0B, (s == 3) ? 2'h2 : s[1:0]};
         rd(8'h06, q);
         chk(q, 8'h00);
         rd(8'h0B, q);
         chk(q, 8'h00);
      end
      strap <= 2'h0;
      probe(7'h2E, k);
      chk({7'h00, k}, 8'h01);
      probe(7'h2C, k);
      chk({7'h00, k}, 8'h00);
      $display("test strap done");
      en <= 1'b1;
      foreach (rows[i]) begin
         {rem, loc, eh, el, ee} <= rows[i];
         wait_valid(33);
         rd(8'h0B, q);
         chk(q, eh);
         rd(8'h0A, q);
         chk(q, el);
         rd(8'h06, q);
         chk(q, ee);
      end
      $display("test format done");
      spread <= 11'h008;
      wait_valid(33);
      rd(8'h0B, q);
      chk(q, 8'h19);
      wr(8'h06, 8'h55);
      rd(8'h06, q);
      chk(q, 8'h28);
      // Two bytes in one read: the master acks the first, nacks the last.
      bus_start;
      xfer({addr, 1'b1}, q, k);
      for (int j = 0; j < 2; j++) begin
         for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
         bit_io(j == 1, k);
         chk(q, 8'h28);
      end
      bus_stop;
      rd(8'h07, q);
      chk(q, 8'h00);
      $display("test average done");
      ara(8'hFF, q, k);
      chk({7'h00, k}, 8'h00);
      cond <= 1'b1;
      wait_int;
      ara(8'hFF, q, k);
      chk({7'h00, k}, 8'h01);
      chk(q, {addr, 1'b0});
      wait_int;
      // Cause removed first, so a held interrupt proves the lost bid; the
      // rival's one after the lost bit shows that this device let go.
      cond <= 1'b0;
      ara(8'h4E, q, k);
      chk(q, 8'h4E);
      chk({7'h00, int_oe_o}, 8'h01);
      ara(8'hFF, q, k);
      chk(q, {addr, 1'b0});
      chk({7'h00, int_oe_o}, 8'h00);
      tick(400);
      chk({7'h00, int_oe_o}, 8'h00);
      $display("test alert done");
      report_and_stop;
   end
endmodule
bind tra_top tra_top_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_o(int_o), .int_oe_o(int_oe_o),
   .strap_level_i(strap_level_i), .adc_start_o(adc_start_o),
   .remote_sample_i(remote_sample_i), .remote_valid_i(remote_valid_i),
   .local_sample_i(local_sample_i), .local_valid_i(local_valid_i),
   .alert_cond_i(alert_cond_i));
